/* File: rtl/phs_port.sv */
// How it works
// - watchdog fault drops the module ok flag
// - host ready raised puts module online
// - host ready dropped returns module offline
// - no online entry for 500 ms after reset
// - lost sensor path raises axis sensor fault
// - sensor fault held until clear and healed
// - any fault follows sensor fault or error
// - any fault cleared by clear once healed
// - valid clear also zeroes stored error code
// - clear acts once per rising edge only
// - preset command rising edge loads axis position
// - preset ignored while module is offline
// - preset loads the written setting value
// - setting disable bit one blocks preset
module phs_port #(
  parameter int SAMPLE_CYC = phs_pkg::SAMPLE_CYC,
  parameter int LOCKOUT_CYC = phs_pkg::LOCKOUT_CYC,
  parameter logic [15:0] SENSOR_ERR_CODE = phs_pkg::SENSOR_CODE_DEF
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic host_ready_cmd_i,
  input wire logic axis1_preset_cmd_i,
  input wire logic axis2_preset_cmd_i,
  input wire logic fault_clear_cmd_i,
  input wire logic axis1_sensor_loss_i,
  input wire logic axis2_sensor_loss_i,
  input wire logic wdt_fault_i,
  input wire logic [1:0] axis_err_i,
  input wire logic [31:0] axis_err_code_i,
  output logic module_ok_flag_o,
  output logic online_status_flag_o,
  output logic axis1_sensor_fault_flag_o,
  output logic axis1_any_fault_flag_o,
  output logic axis2_sensor_fault_flag_o,
  output logic axis2_any_fault_flag_o,
  output logic [1:0] preset_load_o,
  output logic [47:0] preset_value_o,
  output logic irq_o
);

  localparam int NAXIS = phs_pkg::NAXIS;
  localparam int POS_W = phs_pkg::POS_W;
  localparam int CODE_W = phs_pkg::CODE_W;
  localparam int DATA_W = phs_pkg::DATA_W;
  localparam int NEV = phs_pkg::NEV;
  localparam int SCW = $clog2(SAMPLE_CYC + 1);
  localparam int LCW = $clog2(LOCKOUT_CYC + 1);

  typedef struct packed {
    logic [SCW-1:0] samp_cnt;
    logic tick;
    logic [LCW-1:0] lock_cnt;
    logic lock_done;
    logic ok;
    logic online;
    logic [NAXIS-1:0] sfault;
    logic [NAXIS-1:0] afault;
    logic [NAXIS-1:0][CODE_W-1:0] ecode;
    logic [NAXIS-1:0][POS_W-1:0] setval;
    logic [NAXIS-1:0] sdis;
    logic [NAXIS-1:0] load;
    logic [NAXIS-1:0][POS_W-1:0] pos;
    logic [NEV-1:0] irq_st;
    logic [NEV-1:0] irq_msk;
    logic irq;
    logic pready;
    logic pslverr;
    logic [DATA_W-1:0] prdata;
  } phs_state_t;

  phs_state_t st;
  phs_state_t next_st;

  logic [phs_pkg::NSIG-1:0] raw;
  logic [NAXIS-1:0] sens_v;
  logic [NAXIS-1:0] clr_v;
  logic [NEV-1:0] ev;
  logic [NEV-1:0] w1c;
  logic [DATA_W-1:0] rdat;
  logic rmap;
  logic wr;

  // ---------------------------------------------------------------
  // host and sensor line sampling
  // ---------------------------------------------------------------
  phs_samp_if smp ();

  assign raw = {axis2_sensor_loss_i, axis1_sensor_loss_i, fault_clear_cmd_i,
                axis2_preset_cmd_i, axis1_preset_cmd_i, host_ready_cmd_i};
  assign smp.tick = st.tick;

  phs_sample u_sample (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .raw_i(raw),
    .smp(smp.src)
  );

  // a clear counts for an axis only once its causes have gone
  assign sens_v = smp.level[phs_pkg::SG_SENS0 +: NAXIS];
  assign clr_v = {NAXIS{smp.rise[phs_pkg::SG_CLR]}} & ~sens_v & ~axis_err_i;

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.load = '0;
    next_st.tick = 1'b0;
    ev = '0;
    w1c = '0;
    rdat = '0;
    rmap = 1'b1;
    wr = psel_i & penable_i & st.pready & pwrite_i;

    // sample period tick
    if (st.samp_cnt == SCW'(SAMPLE_CYC - 1)) begin
      next_st.samp_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.samp_cnt = st.samp_cnt + 1'b1;
    end

    // start-up lockout after any reset
    if (!st.lock_done) begin
      if (st.lock_cnt == LCW'(LOCKOUT_CYC - 1)) begin
        next_st.lock_done = 1'b1;
      end else begin
        next_st.lock_cnt = st.lock_cnt + 1'b1;
      end
    end

    // self-diagnosis fault is sticky until reset
    if (wdt_fault_i) begin
      next_st.ok = 1'b0;
    end

    // online follows host ready once the lockout has run out
    next_st.online = smp.level[phs_pkg::SG_READY] & st.lock_done;

    for (int a = 0; a < NAXIS; a++) begin
      if (sens_v[a]) begin
        next_st.sfault[a] = 1'b1;
      end else if (clr_v[a]) begin
        next_st.sfault[a] = 1'b0;
      end
      if (next_st.sfault[a] | axis_err_i[a]) begin
        next_st.afault[a] = 1'b1;
      end else if (clr_v[a]) begin
        next_st.afault[a] = 1'b0;
      end
      if (axis_err_i[a]) begin
        next_st.ecode[a] = axis_err_code_i[a*CODE_W +: CODE_W];
      end else if (sens_v[a]) begin
        next_st.ecode[a] = SENSOR_ERR_CODE;
      end else if (clr_v[a]) begin
        next_st.ecode[a] = phs_pkg::CODE_CLEAR;
      end
      if (smp.rise[phs_pkg::SG_PRE0 + a] & st.online & ~st.sdis[a]) begin
        next_st.load[a] = 1'b1;
        next_st.pos[a] = st.setval[a];
      end
      ev[phs_pkg::EV_AF0 + a] = next_st.afault[a] & ~st.afault[a];
      ev[phs_pkg::EV_LOAD0 + a] = next_st.load[a];
    end

    ev[phs_pkg::EV_ONLINE] = next_st.online & ~st.online;
    ev[phs_pkg::EV_OFFLINE] = ~next_st.online & st.online;
    ev[phs_pkg::EV_WDT] = ~next_st.ok & st.ok;

    // register read decode
    case (paddr_i)
      phs_pkg::OFF_STATUS: begin
        rdat[phs_pkg::ST_OK] = st.ok;
        rdat[phs_pkg::ST_ONLINE] = st.online;
        rdat[phs_pkg::ST_SF0] = st.sfault[0];
        rdat[phs_pkg::ST_AF0] = st.afault[0];
        rdat[phs_pkg::ST_SF1] = st.sfault[1];
        rdat[phs_pkg::ST_AF1] = st.afault[1];
        rdat[phs_pkg::ST_LOCK] = ~st.lock_done;
      end
      phs_pkg::OFF_ERRCODE0: begin
        rdat[CODE_W-1:0] = st.ecode[0];
      end
      phs_pkg::OFF_ERRCODE1: begin
        rdat[CODE_W-1:0] = st.ecode[1];
      end
      phs_pkg::OFF_SETVAL0: begin
        rdat[POS_W-1:0] = st.setval[0];
      end
      phs_pkg::OFF_SETVAL1: begin
        rdat[POS_W-1:0] = st.setval[1];
      end
      phs_pkg::OFF_SETDIS0: begin
        rdat[phs_pkg::SETDIS_BIT] = st.sdis[0];
      end
      phs_pkg::OFF_SETDIS1: begin
        rdat[phs_pkg::SETDIS_BIT] = st.sdis[1];
      end
      phs_pkg::OFF_CMDSTAT: begin
        rdat[phs_pkg::CMD_PRE0] = smp.level[phs_pkg::SG_PRE0];
        rdat[phs_pkg::CMD_PRE1] = smp.level[phs_pkg::SG_PRE0 + 1];
      end
      phs_pkg::OFF_IRQ_ST: begin
        rdat[NEV-1:0] = st.irq_st;
      end
      phs_pkg::OFF_IRQ_MSK: begin
        rdat[NEV-1:0] = st.irq_msk;
      end
      default: begin
        rmap = 1'b0;
      end
    endcase

    // register writes, on the completing access edge only
    if (wr & rmap) begin
      case (paddr_i)
        phs_pkg::OFF_SETVAL0: begin
          next_st.setval[0] = pwdata_i[POS_W-1:0];
        end
        phs_pkg::OFF_SETVAL1: begin
          next_st.setval[1] = pwdata_i[POS_W-1:0];
        end
        phs_pkg::OFF_SETDIS0: begin
          next_st.sdis[0] = pwdata_i[phs_pkg::SETDIS_BIT];
        end
        phs_pkg::OFF_SETDIS1: begin
          next_st.sdis[1] = pwdata_i[phs_pkg::SETDIS_BIT];
        end
        phs_pkg::OFF_IRQ_ST: begin
          w1c = pwdata_i[NEV-1:0];
        end
        phs_pkg::OFF_IRQ_MSK: begin
          next_st.irq_msk = pwdata_i[NEV-1:0];
        end
        default: begin
          w1c = '0;
        end
      endcase
    end

    // a new event wins over a clear in the same cycle
    next_st.irq_st = (st.irq_st & ~w1c) | ev;
    next_st.irq = |(next_st.irq_st & next_st.irq_msk);

    // one wait state: pready is set at the end of the first access cycle
    if (psel_i & penable_i & ~st.pready) begin
      next_st.pready = 1'b1;
      next_st.prdata = rdat;
      next_st.pslverr = ~rmap;
    end else begin
      next_st.pready = 1'b0;
      next_st.pslverr = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.ok <= phs_pkg::OK_RST;
    end else begin
      st <= next_st;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign prdata_o = st.prdata;
  assign pready_o = st.pready;
  assign pslverr_o = st.pslverr;
  assign module_ok_flag_o = st.ok;
  assign online_status_flag_o = st.online;
  assign axis1_sensor_fault_flag_o = st.sfault[0];
  assign axis1_any_fault_flag_o = st.afault[0];
  assign axis2_sensor_fault_flag_o = st.sfault[1];
  assign axis2_any_fault_flag_o = st.afault[1];
  assign preset_load_o = st.load;
  assign preset_value_o = st.pos;
  assign irq_o = st.irq;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  AST_OK_DROP: assert property (
    wdt_fault_i |=> !module_ok_flag_o [*3])
    else $error("ok flag not dropped after watchdog fault");

  AST_ONLINE_SET: assert property (
    (smp.level[phs_pkg::SG_READY] && st.lock_done) |=> online_status_flag_o)
    else $error("module not online with host ready");

  AST_OFFLINE: assert property (
    !smp.level[phs_pkg::SG_READY] |=> !online_status_flag_o)
    else $error("module online without host ready");

  AST_LOCKOUT: assert property (
    !st.lock_done |=> !online_status_flag_o)
    else $error("module online during start-up lockout");

  AST_SENS_SET: assert property (
    sens_v[0] |=> axis1_sensor_fault_flag_o && axis1_any_fault_flag_o)
    else $error("sensor fault not flagged");

  AST_SENS_HOLD: assert property (
    (axis1_sensor_fault_flag_o && !clr_v[0]) |=> axis1_sensor_fault_flag_o)
    else $error("sensor fault dropped without valid clear");

  AST_ANY_COVERS: assert property (
    (axis2_sensor_fault_flag_o || $past(axis_err_i[1])) |-> axis2_any_fault_flag_o)
    else $error("any fault flag missing its cause");

  AST_ANY_CLEAR: assert property (
    clr_v[0] |=> !axis1_any_fault_flag_o && !axis1_sensor_fault_flag_o)
    else $error("fault flags not cleared by valid clear");

  AST_CODE_CLEAR: assert property (
    clr_v[1] |=> (st.ecode[1] == phs_pkg::CODE_CLEAR))
    else $error("error code not zeroed by valid clear");

  AST_PRESET_LOAD: assert property (
    (smp.rise[phs_pkg::SG_PRE0] && st.online && !st.sdis[0])
      |=> preset_load_o[0] && (preset_value_o[POS_W-1:0] == $past(st.setval[0])))
    else $error("preset not loaded with setting value");

  AST_PRESET_OFFLINE: assert property (
    !online_status_flag_o |=> (preset_load_o == '0))
    else $error("preset executed while offline");

  AST_PRESET_DIS: assert property (
    st.sdis[1] |=> !preset_load_o[1])
    else $error("preset executed while disabled");

  COV_ONLINE: cover property (!online_status_flag_o ##1 online_status_flag_o);
  COV_CLEAR: cover property (axis1_any_fault_flag_o ##1 !axis1_any_fault_flag_o);
  COV_PRESET: cover property (preset_load_o[1]);
  COV_IRQ: cover property (!irq_o ##1 irq_o);

endmodule

/* File: rtl/phs_pkg.sv */
package phs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SAMPLE_PERIOD_US = 400;
  localparam int SAMPLE_CYC = (SAMPLE_PERIOD_US * 1000) / CLK_PERIOD_NS;
  localparam int LOCKOUT_MS = 500;
  // least time: rounded up to whole cycles
  localparam int LOCKOUT_CYC = (LOCKOUT_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int NAXIS = 2;
  localparam int POS_W = 24;
  localparam int CODE_W = 16;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------
  // sampled input slots
  // ---------------------------------------------------------------
  localparam int NSIG = 6;
  localparam int SG_READY = 0;
  localparam int SG_PRE0 = 1;
  localparam int SG_CLR = 3;
  localparam int SG_SENS0 = 4;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h000;
  localparam logic [ADDR_W-1:0] OFF_ERRCODE0 = 12'h004;
  localparam logic [ADDR_W-1:0] OFF_ERRCODE1 = 12'h008;
  localparam logic [ADDR_W-1:0] OFF_SETVAL0 = 12'h00C;
  localparam logic [ADDR_W-1:0] OFF_SETVAL1 = 12'h010;
  localparam logic [ADDR_W-1:0] OFF_SETDIS0 = 12'h014;
  localparam logic [ADDR_W-1:0] OFF_SETDIS1 = 12'h018;
  localparam logic [ADDR_W-1:0] OFF_CMDSTAT = 12'h01C;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ST = 12'h020;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MSK = 12'h024;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int ST_OK = 0;
  localparam int ST_ONLINE = 1;
  localparam int ST_SF0 = 4;
  localparam int ST_AF0 = 5;
  localparam int ST_SF1 = 8;
  localparam int ST_AF1 = 9;
  localparam int ST_LOCK = 12;
  localparam int CMD_PRE0 = 0;
  localparam int CMD_PRE1 = 1;
  localparam int SETDIS_BIT = 0;

  localparam int NEV = 7;
  localparam int EV_ONLINE = 0;
  localparam int EV_OFFLINE = 1;
  localparam int EV_AF0 = 2;
  localparam int EV_LOAD0 = 4;
  localparam int EV_WDT = 6;

  // ---------------------------------------------------------------
  // reset and error code values
  // ---------------------------------------------------------------
  localparam logic OK_RST = 1'h1;
  localparam logic [CODE_W-1:0] CODE_CLEAR = 16'h0000;
  localparam logic [CODE_W-1:0] SENSOR_CODE_DEF = 16'h0001;

endpackage

/* File: rtl/phs_samp_if.sv */
interface phs_samp_if;
  logic tick;
  logic [phs_pkg::NSIG-1:0] level;
  logic [phs_pkg::NSIG-1:0] rise;

  modport src (
    input tick,
    output level,
    output rise
  );

  modport dst (
    output tick,
    input level,
    input rise
  );
endinterface

/* File: rtl/phs_sample.sv */
module phs_sample (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [phs_pkg::NSIG-1:0] raw_i,
  phs_samp_if.src smp
);

  localparam int NSIG = phs_pkg::NSIG;
  localparam int SG_CLR = phs_pkg::SG_CLR;

  typedef struct packed {
    logic [NSIG-1:0] meta;
    logic [NSIG-1:0] sync;
    logic [NSIG-1:0] level;
    logic [NSIG-1:0] rise;
  } phs_samp_state_t;

  phs_samp_state_t st;
  phs_samp_state_t next_st;

  // ---------------------------------------------------------------
  // two-stage sync, then sample and compare once per period
  // ---------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.meta = raw_i;
    next_st.sync = st.meta;
    next_st.rise = '0;
    if (smp.tick) begin
      next_st.level = st.sync;
      next_st.rise = st.sync & ~st.level;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign smp.level = st.level;
  assign smp.rise = st.rise;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_RISE_ON_TICK: assert property (@(posedge clk_i) disable iff (rst_i)
    (smp.rise != '0) |-> $past(smp.tick) && (smp.rise == (smp.level & ~$past(smp.level))))
    else $error("rise seen without a sample tick or edge");

  AST_CLR_ONCE: assert property (@(posedge clk_i) disable iff (rst_i)
    smp.rise[SG_CLR] |=> !smp.rise[SG_CLR] ##1 !smp.rise[SG_CLR])
    else $error("fault clear edge fired twice");

endmodule

/* File: sim/phs_host.sv */
module phs_host #(
  parameter int HOLD = 20
) (
  input wire logic clk_i,
  output logic host_ready_cmd_o,
  output logic axis1_preset_cmd_o,
  output logic axis2_preset_cmd_o,
  output logic fault_clear_cmd_o
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    host_ready_cmd_o = 1'b0;
    axis1_preset_cmd_o = 1'b0;
    axis2_preset_cmd_o = 1'b0;
    fault_clear_cmd_o = 1'b0;
  end
  // only documented lines switch; every level held longer than a sample period
  task automatic drive(input int idx, input logic v);
    @(posedge clk_i);
    case (idx)
      0: host_ready_cmd_o <= v;
      1: axis1_preset_cmd_o <= v;
      2: axis2_preset_cmd_o <= v;
      default: fault_clear_cmd_o <= v;
    endcase
    repeat (HOLD) @(posedge clk_i);
  endtask
endmodule

/* File: sim/phs_port_bench.sv */
module phs_port_bench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int SC = 4;
  localparam int LOCK = 50;
  localparam int HOLD = 3 * SC + 8;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, wdt = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, acode = 32'h0, prdata, rd;
  logic [1:0] loss = 2'h0, aerr = 2'h0, pload;
  logic pready, pslverr, hrdy, pre1, pre2, clr, ok, onl, irq, er;
  logic [3:0] fl;
  logic [47:0] pval;
  logic [23:0] lval [2];
  int loads [2] = '{0, 0};
  int seed = 88067;
  int miscompares = 0;
  int n_compared = 0;

  always #2.5 clk_i = ~clk_i;

  phs_port #(.SAMPLE_CYC(SC), .LOCKOUT_CYC(LOCK)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .host_ready_cmd_i(hrdy), .axis1_preset_cmd_i(pre1),
    .axis2_preset_cmd_i(pre2), .fault_clear_cmd_i(clr), .axis1_sensor_loss_i(loss[0]),
    .axis2_sensor_loss_i(loss[1]), .wdt_fault_i(wdt), .axis_err_i(aerr),
    .axis_err_code_i(acode), .module_ok_flag_o(ok), .online_status_flag_o(onl),
    .axis1_sensor_fault_flag_o(fl[0]), .axis1_any_fault_flag_o(fl[1]),
    .axis2_sensor_fault_flag_o(fl[2]), .axis2_any_fault_flag_o(fl[3]),
    .preset_load_o(pload), .preset_value_o(pval), .irq_o(irq));

  phs_host #(.HOLD(HOLD)) uhost (
    .clk_i(clk_i), .host_ready_cmd_o(hrdy), .axis1_preset_cmd_o(pre1),
    .axis2_preset_cmd_o(pre2), .fault_clear_cmd_o(clr));

  // counts load pulses and keeps the value that came with each
  always @(posedge clk_i) begin
    for (int i = 0; i < 2; i++) begin
      if (pload[i] === 1'b1) begin
        loads[i]++;
        lval[i] = pval[24*i +: 24];
      end
    end
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_i);
    miscompares++;
    final_report();
  end

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    // pready, prdata and pslverr are read as they stood at the completing edge
    for (n = 0; n < 50; n++) begin
      @(posedge clk_i);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 50) begin
      miscompares++;
      final_report();
    end
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    check(nm, rd, exp);
  endtask

  task automatic chk_irq(input logic exp);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    check("irq", irq, exp);
  endtask

  function automatic logic [31:0] exp_st(input logic o, input logic n, input logic [3:0] f);
    return {22'h0, f[3:2], 2'h0, f[1:0], 2'h0, n, o};
  endfunction

  task automatic chk_st(input logic o, input logic n, input logic [3:0] f);
    @(negedge clk_i);
    check("pins", {ok, onl, fl}, {o, n, f});
    rdc(phs_pkg::OFF_STATUS, exp_st(o, n, f), "status");
  endtask

  task automatic preset(input int ax, input logic dis, input logic on);
    int n0;
    logic [11:0] va;
    logic [23:0] sv;
    va = ax ? phs_pkg::OFF_SETVAL1 : phs_pkg::OFF_SETVAL0;
    sv = 24'($random(seed));
    apb(1'b1, va, {8'hA5, sv});
    rdc(va, {8'h00, sv}, "setval");
    apb(1'b1, ax ? phs_pkg::OFF_SETDIS1 : phs_pkg::OFF_SETDIS0, {31'h0, dis});
    n0 = loads[ax];
    uhost.drive(ax + 1, 1'b1);
    rdc(phs_pkg::OFF_CMDSTAT, 32'h1 << ax, "cmd level");
    uhost.drive(ax + 1, 1'b0);
    check("loads", loads[ax] - n0, on & !dis);
    if (on & !dis) check("load value", lval[ax], sv);
  endtask

  task automatic fault_case(input int ax);
    logic [3:0] s, a;
    logic [11:0] ca;
    logic [15:0] c;
    s = 4'h1 << (2 * ax);
    a = s << 1;
    ca = ax ? phs_pkg::OFF_ERRCODE1 : phs_pkg::OFF_ERRCODE0;
    c = 16'($random(seed)) | 16'h0002;
    loss[ax] <= 1'b1;
    repeat (HOLD) @(posedge clk_i);
    chk_st(1'b1, 1'b1, s | a);
    rdc(ca, 32'(phs_pkg::SENSOR_CODE_DEF), "code");
    uhost.drive(3, 1'b1);
    uhost.drive(3, 1'b0);
    chk_st(1'b1, 1'b1, s | a);
    loss[ax] <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
    chk_st(1'b1, 1'b1, s | a);
    uhost.drive(3, 1'b1);
    chk_st(1'b1, 1'b1, 4'h0);
    rdc(ca, 32'h0, "code");
    aerr[ax] <= 1'b1;
    acode[16*ax +: 16] <= c;
    repeat (HOLD) @(posedge clk_i);
    chk_st(1'b1, 1'b1, a);
    rdc(ca, {16'h0, c}, "code");
    aerr[ax] <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
    chk_st(1'b1, 1'b1, a);
    uhost.drive(3, 1'b0);
    uhost.drive(3, 1'b1);
    chk_st(1'b1, 1'b1, 4'h0);
    rdc(ca, 32'h0, "code");
    uhost.drive(3, 1'b0);
  endtask

  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    check("reset pins", {ok, onl, fl, irq}, 7'h40);
    rdc(phs_pkg::OFF_SETVAL0, 32'h0, "setval reset");
    rdc(phs_pkg::OFF_SETDIS1, 32'h0, "setdis reset");
    rdc(phs_pkg::OFF_IRQ_MSK, 32'h0, "mask reset");
    apb(1'b0, 12'h028, 32'h0);
    check("unmapped err", er, 1'b1);
    check("unmapped data", rd, 32'h0);
    $display("test reset done");
    uhost.drive(0, 1'b1);
    check("online in lockout", onl, 1'b0);
    repeat (LOCK) @(posedge clk_i);
    chk_st(1'b1, 1'b1, 4'h0);
    rdc(phs_pkg::OFF_IRQ_ST, 32'h1, "irq status");
    chk_irq(1'b0);
    apb(1'b1, phs_pkg::OFF_IRQ_MSK, 32'h1);
    chk_irq(1'b1);
    apb(1'b1, phs_pkg::OFF_IRQ_ST, 32'h1);
    chk_irq(1'b0);
    $display("test online done");
    for (int i = 0; i < 6; i++) begin
      preset(i % 2, i >= 4, 1'b1);
    end
    $display("test preset done");
    fault_case(0);
    fault_case(1);
    $display("test fault done");
    uhost.drive(0, 1'b0);
    chk_st(1'b1, 1'b0, 4'h0);
    preset(0, 1'b0, 1'b0);
    rdc(phs_pkg::OFF_IRQ_ST, 32'h3E, "irq status");
    apb(1'b1, phs_pkg::OFF_IRQ_ST, 32'h7F);
    apb(1'b1, phs_pkg::OFF_IRQ_MSK, 32'h40);
    @(posedge clk_i);
    wdt <= 1'b1;
    @(posedge clk_i);
    wdt <= 1'b0;
    repeat (HOLD) @(posedge clk_i);
    chk_st(1'b0, 1'b0, 4'h0);
    rdc(phs_pkg::OFF_IRQ_ST, 32'h40, "irq status");
    chk_irq(1'b1);
    $display("test watchdog done");
    final_report();
  end
endmodule
